/* dv/dcr_bank_checker.sv */
/*
 Port assertions for the register bank.
 Assumes request events stay quiet around clear and reset writes.
*/
`timescale 1ns/1ns
`default_nettype none
module dcr_bank_checker (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic [15:0] SAMPLE_DATA,
    input wire logic SAMPLE_VALID,
    input wire logic DAC_MIDSCALE_STRAP,
    input wire logic CONVERSION_TRIGGER,
    input wire logic BOARD_RESET,
    input wire logic FIFO_RESET,
    input wire logic DAC_RESET,
    input wire logic [11:0] DAC_RESET_VALUE,
    input wire logic CONVERSION_STATUS_FLAG,
    input wire logic [3:0] REQUEST_FLAGS,
    input wire logic IRQ,
    input wire logic [7:0] DIRECTION,
    input wire logic [7:0] IRQ_CONTROL
);
    logic [7:0] last_hi;
    logic cmd;
    logic clr1;
    assign cmd = WR && ADDR == 4'h0;
    assign clr1 = cmd && (WDATA[1] || WDATA[6]);
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) last_hi <= 8'h00;
        else if (BOARD_RESET) last_hi <= 8'h00;
        else if (SAMPLE_VALID) last_hi <= SAMPLE_DATA[15:8];
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_wiped;
        BOARD_RESET ##1 (REQUEST_FLAGS == 4'h0 && IRQ_CONTROL == 8'h00 && DIRECTION == 8'h00);
    endsequence
    property p_start;
        cmd && WDATA[7] && !WDATA[6] && !IRQ_CONTROL[0]
            |-> ##2 (CONVERSION_TRIGGER && CONVERSION_STATUS_FLAG);
    endproperty
    property p_wipe; cmd && WDATA[6] |=> s_wiped; endproperty
    property p_fifo; cmd && WDATA[4] |=> FIFO_RESET; endproperty
    property p_dac;
        cmd && WDATA[5] |=> DAC_RESET && DAC_RESET_VALUE == (DAC_MIDSCALE_STRAP ? 12'h800 : 12'h000);
    endproperty
    property p_quiet; cmd && WDATA == 8'h00 |=> !(BOARD_RESET || FIFO_RESET || DAC_RESET); endproperty
    property p_clear; cmd && WDATA[0] |-> ##[1:2] !REQUEST_FLAGS[0]; endproperty
    property p_hold; REQUEST_FLAGS[1] && !clr1 && !$past(clr1) |=> REQUEST_FLAGS[1]; endproperty
    property p_irq; IRQ == (REQUEST_FLAGS != 4'h0); endproperty
    property p_unused; RD && (ADDR == 4'h5 || ADDR == 4'h6) |=> RDATA[7:6] == 2'b00; endproperty
    property p_split; RD && ADDR == 4'h1 |=> RDATA == $past(last_hi); endproperty
    a_start: assert property (p_start) else $error("software start gave no trigger");
    a_wipe: assert property (p_wipe) else $error("board reset left state");
    a_fifo: assert property (p_fifo) else $error("fifo reset pulse missing");
    a_dac: assert property (p_dac) else $error("analog output reset wrong");
    a_quiet: assert property (p_quiet) else $error("zero command acted");
    a_clear: assert property (p_clear) else $error("analog request not cleared");
    a_hold: assert property (p_hold) else $error("request dropped uncleared");
    a_irq: assert property (p_irq) else $error("request without irq");
    a_unused: assert property (p_unused) else $error("unused bits not zero");
    a_split: assert property (p_split) else $error("high byte mismatch");
endmodule : dcr_bank_checker
bind dcr_bank dcr_bank_checker dcr_bank_checker_i (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SAMPLE_DATA(SAMPLE_DATA),
    .SAMPLE_VALID(SAMPLE_VALID), .DAC_MIDSCALE_STRAP(DAC_MIDSCALE_STRAP),
    .CONVERSION_TRIGGER(CONVERSION_TRIGGER), .BOARD_RESET(BOARD_RESET), .FIFO_RESET(FIFO_RESET),
    .DAC_RESET(DAC_RESET), .DAC_RESET_VALUE(DAC_RESET_VALUE), .IRQ(IRQ),
    .CONVERSION_STATUS_FLAG(CONVERSION_STATUS_FLAG), .REQUEST_FLAGS(REQUEST_FLAGS),
    .DIRECTION(DIRECTION), .IRQ_CONTROL(IRQ_CONTROL));
`default_nettype wire

/* dv/dcr_conv_model.sv */
/*
 Behavioural converter on the far side of the register bank.
 Assumes the bank's one-cycle trigger pulse and a single clock.
*/
`timescale 1ns/1ns
`default_nettype none
module dcr_conv_model #(
    parameter int LAT = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic trig,
    input wire logic [15:0] value,
    output logic busy,
    output logic valid,
    output logic [15:0] data
);
    logic [3:0] cnt;
    logic [15:0] last;
    // Busy spans the whole conversion, result follows its end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            busy <= 1'b0;
            valid <= 1'b0;
            last <= 16'h0000;
        end else begin
            valid <= 1'b0;
            if (trig) begin
                busy <= 1'b1;
                cnt <= 4'(LAT);
            end else if (cnt > 4'h1) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                valid <= 1'b1;
                last <= value;
            end
        end
    end
    // Stale bus shows inverted data, never a held copy
    assign data = valid ? last : ~last;
endmodule : dcr_conv_model
`default_nettype wire

/* dv/tb.sv */
/*
 Self-checking bench for the register bank, acting as host.
 Assumes the converter model and the bound checker alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dcr_pkg::*;
    localparam logic [7:0] REV = 8'hA5;  // Arbitrary revision value
    logic CLOCK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, tick = 1'b0, ext = 1'b0, strap = 1'b0;
    logic lvl = 1'b0, saw, SAMPLE_VALID, CONVERTER_BUSY, CONVERSION_TRIGGER, IRQ;
    logic [3:0] ADDR = 4'h0, ev = 4'h0;
    logic [7:0] WDATA = 8'h00, RDATA, d, v, pin = 8'h00;
    logic [15:0] smp = 16'h0000, SAMPLE_DATA;
    logic [11:0] DAC_RESET_VALUE, DAC_CODE;
    logic [3:0] offs [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'hB};
    logic [15:0] cases [4];
    int n_fail = 0, checks_done = 0, n_trig = 0, nt, k, seed = 32'h42DE8877;
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) if (CONVERSION_TRIGGER === 1'b1) n_trig++;
    dcr_conv_model dcr_conv_model_i (.clk(CLOCK), .nrst(NRST), .trig(CONVERSION_TRIGGER),
        .value(smp), .busy(CONVERTER_BUSY), .valid(SAMPLE_VALID), .data(SAMPLE_DATA));
    dcr_bank #(.REVISION_CODE(REV)) dcr_bank_i (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SAMPLE_DATA(SAMPLE_DATA),
        .SAMPLE_VALID(SAMPLE_VALID), .CONVERTER_BUSY(CONVERTER_BUSY), .SETTLE_WAIT(lvl),
        .DAC_BUSY(lvl), .FIFO_OVERFLOW(lvl), .SINGLE_ENDED(lvl), .FIFO_DEPTH({6{lvl}}),
        .CURRENT_CHANNEL({4{lvl}}), .COUNTER0_TICK(tick), .EXT_TRIGGER(ext),
        .DMA_EVENT(ev[3]), .TIMER_EVENT(ev[2]), .DIGITAL_EVENT(ev[1]), .ANALOG_EVENT(ev[0]),
        .DAC_MIDSCALE_STRAP(strap), .PORT_A_IN(pin), .PORT_B_IN(pin),
        .PORT_C_IN(pin), .CONVERSION_TRIGGER(CONVERSION_TRIGGER), .BOARD_RESET(),
        .FIFO_RESET(), .DAC_RESET(), .DAC_RESET_VALUE(DAC_RESET_VALUE), .DAC_LOAD(),
        .DAC_CHANNEL(), .DAC_CODE(DAC_CODE), .CONVERSION_STATUS_FLAG(), .REQUEST_FLAGS(),
        .IRQ(IRQ), .PORT_A_OUT(), .PORT_B_OUT(), .PORT_C_OUT(), .DIRECTION(), .SCAN_RANGE(),
        .GAIN_SCAN(), .IRQ_CONTROL(), .FIFO_THRESHOLD(), .COUNTER_DATA(), .COUNTER_COMMAND(),
        .COUNTER_COMMAND_STROBE());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge CLOCK);
        #1 WR = 1'b1;
        ADDR = a;
        WDATA = x;
        @(posedge CLOCK);
        #1 WR = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] x);
        @(posedge CLOCK);
        #1 RD = 1'b1;
        ADDR = a;
        @(posedge CLOCK);
        #1 RD = 1'b0;
        x = RDATA;
    endtask : rd
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a, d);
        chk(16'(d), 16'(e));
    endtask : rdc
    // Readable share of each written byte
    function automatic logic [7:0] wmask(input logic [3:0] a);
        case (a)
            OFS_SCAN_RANGE: return 8'hFF;
            OFS_GAIN_STATUS: return MASK_GAIN_SCAN;
            OFS_FIFO_THRESH: return MASK_FIFO_THRESH;
            OFS_DIR_CTRL: return MASK_DIR_CTRL;
            default: return 8'h00;
        endcase
    endfunction : wmask
    task automatic convert(input logic [15:0] x);
        logic [7:0] lo;
        smp = x;
        wr(OFS_CMD_LOW, 8'h80);
        saw = 1'b0;
        // Poll bounded: busy must show, then clear
        for (k = 0; k < 40; k++) begin
            rd(OFS_GAIN_STATUS, d);
            if (d[7]) saw = 1'b1;
            else if (saw) break;
        end
        chk(16'(saw), 16'h0001);
        chk(16'(d[7]), 16'h0000);
        rd(OFS_CMD_LOW, lo);
        rd(OFS_SAMPLE_HIGH, d);
        chk(16'(lo) + 16'(d) * 16'd256, x);
    endtask : convert
    task automatic events;
        @(posedge CLOCK);
        #1 ev = 4'hF;
        repeat (4) @(posedge CLOCK);
        #1 ev = 4'h0;
        repeat (4) @(posedge CLOCK);
    endtask : events
    task automatic close_out;
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
    initial begin
        strap = 1'($random(seed));
        cases = '{16'h8000, 16'h7FFF, 16'($random(seed)), 16'($random(seed))};
        repeat (2) @(posedge CLOCK);
        #1 NRST = 1'b1;
        for (int a = 0; a < 16; a++) rdc(4'(a), a == 15 ? REV : 8'h00);
        for (int i = 0; i < 25; i++) begin
            v = 8'($random(seed));
            wr(offs[i % 5], v);
            rdc(offs[i % 5], v & wmask(offs[i % 5]));
        end
        foreach (cases[i]) convert(cases[i]);
        wr(OFS_IRQ_CTRL, 8'h01);
        nt = n_trig;
        wr(OFS_CMD_LOW, 8'h80);
        repeat (4) @(posedge CLOCK);
        chk(16'(n_trig - nt), 16'h0000);
        #1 tick = 1'b1;
        @(posedge CLOCK);
        #1 tick = 1'b0;
        wr(OFS_IRQ_CTRL, 8'h11);
        #1 ext = 1'b1;
        repeat (4) @(posedge CLOCK);
        #1 ext = 1'b0;
        repeat (12) @(posedge CLOCK);
        chk(16'(n_trig - nt), 16'h0002);
        wr(OFS_IRQ_CTRL, 8'h0F);
        events();
        rdc(OFS_DAC_HIGH_FLAGS, 8'hF0);
        wr(OFS_CMD_LOW, 8'h00);
        repeat (20) @(posedge CLOCK);
        rdc(OFS_DAC_HIGH_FLAGS, 8'hF0);
        chk(16'(IRQ), 16'h0001);
        wr(OFS_CMD_LOW, 8'h09);
        rdc(OFS_DAC_HIGH_FLAGS, 8'h60);
        wr(OFS_CMD_LOW, 8'h06);
        rdc(OFS_DAC_HIGH_FLAGS, 8'h00);
        chk(16'(IRQ), 16'h0000);
        wr(OFS_CMD_LOW, 8'h30);
        chk(16'(DAC_RESET_VALUE), strap ? 16'h0800 : 16'h0000);
        wr(OFS_DAC_LOW_DEPTH, 8'h34);
        wr(OFS_DAC_HIGH_FLAGS, 8'h42);
        wr(OFS_DIR_CTRL, 8'h9B);
        wr(OFS_PORT_A, 8'h3C);
        rdc(OFS_PORT_A, 8'h3C);
        events();
        #1 pin = 8'hC3;
        wr(OFS_CMD_LOW, 8'h40);
        for (int a = 0; a < 15; a++) rdc(4'(a), (a >= 8 && a <= 10) ? pin : 8'h00);
        chk(16'(DAC_CODE), 16'h0234);
        close_out();
    end
endmodule : tb
`default_nettype wire

/* verilog/dcr_bank.sv */
/*
 Register bank of the data acquisition subsystem: sixteen byte-wide I/O
 locations, self-clearing command triggers, converter result bytes,
 request flags and board-level reset of the register state.
 Assumes a host I/O bus synchronous to CLOCK with one-cycle read and write
 strobes, and converter, FIFO, DAC and counter logic outside this block.
*/
// Operation
// - Unused readable bits return zero; unused written bits do nothing.
// - Command bits are pulse triggers; writing one acts, writing zero does nothing.
// - Several command bits set in one write all act together; here board reset in the same write blocks the conversion start.
// - Conversion start with analog interrupt disabled starts conversion, raises status.
// - With analog interrupt enabled, software start is ignored; selected trigger used.
// - Board reset clears all registers and halts activity, keeps analog outputs.
// - Board reset returns all three digital ports to input direction.
// - Analog output reset sets four outputs to mid or zero by strap.
// - FIFO reset command sets sample FIFO depth to zero.
// - Command bits three to zero clear DMA, timer, digital, analog requests.
// - A raised request stays set until cleared; no new requests meanwhile.
// - Result low byte at offset zero, high byte at offset one.
// - Result is a two's-complement sixteen-bit value.
// - Trigger select zero uses counter zero output, one the external trigger.
// - Conversion status reads one while converting or scanning, else zero.
`timescale 1ns/1ns
`default_nettype none
module dcr_bank #(
    parameter logic [7:0] REVISION_CODE = 8'h5A  // Arbitrary revision value
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [15:0] SAMPLE_DATA,
    input wire logic SAMPLE_VALID,
    input wire logic CONVERTER_BUSY,
    input wire logic SETTLE_WAIT,
    input wire logic DAC_BUSY,
    input wire logic FIFO_OVERFLOW,
    input wire logic SINGLE_ENDED,
    input wire logic [5:0] FIFO_DEPTH,
    input wire logic [3:0] CURRENT_CHANNEL,
    input wire logic COUNTER0_TICK,
    input wire logic EXT_TRIGGER,
    input wire logic DMA_EVENT,
    input wire logic TIMER_EVENT,
    input wire logic DIGITAL_EVENT,
    input wire logic ANALOG_EVENT,
    input wire logic DAC_MIDSCALE_STRAP,
    input wire logic [7:0] PORT_A_IN,
    input wire logic [7:0] PORT_B_IN,
    input wire logic [7:0] PORT_C_IN,
    output logic CONVERSION_TRIGGER,
    output logic BOARD_RESET,
    output logic FIFO_RESET,
    output logic DAC_RESET,
    output logic [11:0] DAC_RESET_VALUE,
    output logic DAC_LOAD,
    output logic [1:0] DAC_CHANNEL,
    output logic [11:0] DAC_CODE,
    output logic CONVERSION_STATUS_FLAG,
    output logic [3:0] REQUEST_FLAGS,
    output logic IRQ,
    output logic [7:0] PORT_A_OUT,
    output logic [7:0] PORT_B_OUT,
    output logic [7:0] PORT_C_OUT,
    output logic [7:0] DIRECTION,
    output logic [7:0] SCAN_RANGE,
    output logic [2:0] GAIN_SCAN,
    output logic [7:0] IRQ_CONTROL,
    output logic [5:0] FIFO_THRESHOLD,
    output logic [23:0] COUNTER_DATA,
    output logic [7:0] COUNTER_COMMAND,
    output logic COUNTER_COMMAND_STROBE
);
    import dcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for the external trigger and events
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] sync_prev;
    wire [4:0] async_in = {EXT_TRIGGER, DMA_EVENT, TIMER_EVENT, DIGITAL_EVENT, ANALOG_EVENT};
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
            sync_prev <= 5'h00;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
            sync_prev <= sync_b;
        end
    end
    wire [4:0] rise = sync_b & ~sync_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_cmd = WR && (ADDR == OFS_CMD_LOW);
    wire wr_range = WR && (ADDR == OFS_SCAN_RANGE);
    wire wr_gain = WR && (ADDR == OFS_GAIN_STATUS);
    wire wr_ctrl = WR && (ADDR == OFS_IRQ_CTRL);
    wire wr_thresh = WR && (ADDR == OFS_FIFO_THRESH);
    wire wr_dac_low = WR && (ADDR == OFS_DAC_LOW_DEPTH);
    wire wr_dac_high = WR && (ADDR == OFS_DAC_HIGH_FLAGS);
    wire wr_pa = WR && (ADDR == OFS_PORT_A);
    wire wr_pb = WR && (ADDR == OFS_PORT_B);
    wire wr_pc = WR && (ADDR == OFS_PORT_C);
    wire wr_dir = WR && (ADDR == OFS_DIR_CTRL);
    wire wr_ctr_l = WR && (ADDR == OFS_CTR_LOW);
    wire wr_ctr_m = WR && (ADDR == OFS_CTR_MID);
    wire wr_ctr_h = WR && (ADDR == OFS_CTR_HIGH);
    wire wr_ctr_c = WR && (ADDR == OFS_CTR_CTRL_REV);

    ////////////////////////////////////////////////////////////////////////////
    // Command pulses, registered so each lasts exactly one cycle
    logic [7:0] cmd_pulse;
    logic fifo_reset;
    wire [7:0] next_cmd_pulse = wr_cmd ? WDATA : 8'h00;  // Every set bit pulses; conversion start is gated below
    // Board reset empties the FIFO too; own flop keeps the output glitch free
    wire next_fifo_reset = next_cmd_pulse[CMD_FIFO_RESET] || next_cmd_pulse[CMD_BOARD_RESET];
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cmd_pulse <= RESET_BYTE;
            fifo_reset <= 1'b0;
        end else begin
            cmd_pulse <= next_cmd_pulse;
            fifo_reset <= next_fifo_reset;
        end
    end
    wire board_reset = cmd_pulse[CMD_BOARD_RESET];

    ////////////////////////////////////////////////////////////////////////////
    // Host-written registers; board reset clears all but the DAC
    logic [7:0] scan_range;
    logic [2:0] gain_scan;
    logic [7:0] irq_ctrl;
    logic [5:0] fifo_thresh;
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic [7:0] dir_ctrl;
    logic [23:0] ctr_data;
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            scan_range <= RESET_BYTE;
            gain_scan <= 3'h0;
            irq_ctrl <= RESET_BYTE;
            fifo_thresh <= RESET_DEPTH;
            port_a <= RESET_BYTE;
            port_b <= RESET_BYTE;
            port_c <= RESET_BYTE;
            dir_ctrl <= RESET_BYTE;
            ctr_data <= 24'h000000;
        end else if (board_reset) begin
            scan_range <= RESET_BYTE;
            gain_scan <= 3'h0;
            irq_ctrl <= RESET_BYTE;
            fifo_thresh <= RESET_DEPTH;
            port_a <= RESET_BYTE;
            port_b <= RESET_BYTE;
            port_c <= RESET_BYTE;
            dir_ctrl <= RESET_BYTE;  // All ports back to input
            ctr_data <= 24'h000000;
        end else begin
            // Unused written bits are masked away
            if (wr_range) scan_range <= WDATA;
            if (wr_gain) gain_scan <= WDATA[2:0];
            if (wr_ctrl) irq_ctrl <= WDATA;
            if (wr_thresh) fifo_thresh <= WDATA[5:0];
            if (wr_pa) port_a <= WDATA;
            if (wr_pb) port_b <= WDATA;
            if (wr_pc) port_c <= WDATA;
            if (wr_dir) dir_ctrl <= WDATA & MASK_DIR_CTRL;
            if (wr_ctr_l) ctr_data[7:0] <= WDATA;
            if (wr_ctr_m) ctr_data[15:8] <= WDATA;
            if (wr_ctr_h) ctr_data[23:16] <= WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DAC staging, untouched by board reset; its own command only pulses DAC_RESET, staged code kept
    logic [7:0] dac_low;
    logic [11:0] dac_code;
    logic [1:0] dac_chan;
    logic dac_load;
    logic dac_reset;
    logic [11:0] dac_reset_value;
    wire [11:0] strap_value = DAC_MIDSCALE_STRAP ? DAC_MID_SCALE : DAC_ZERO_SCALE;
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            dac_low <= RESET_BYTE;
            dac_code <= RESET_DAC;
            dac_chan <= 2'h0;
            dac_load <= 1'b0;
            dac_reset <= 1'b0;
            dac_reset_value <= RESET_DAC;
        end else begin
            if (wr_dac_low) dac_low <= WDATA;
            if (wr_dac_high) begin
                dac_code <= {WDATA[3:0], dac_low};
                dac_chan <= WDATA[7:6];
            end
            dac_load <= wr_dac_high;
            dac_reset <= next_cmd_pulse[CMD_ANALOG_OUT_RESET];  // Same cycle as others
            dac_reset_value <= strap_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion triggering and status
    wire analog_int_en = irq_ctrl[CTL_ANALOG_INT_ENABLE];
    wire hw_trigger = irq_ctrl[CTL_TRIGGER_SELECT] ? rise[4] : COUNTER0_TICK;
    // Software start only in software-trigger mode
    wire sw_start = cmd_pulse[CMD_CONVERSION_START] && !analog_int_en;
    wire start = !board_reset && (sw_start || (analog_int_en && hw_trigger));
    logic trig;
    logic pending;
    logic status_flag;
    logic [15:0] sample;
    // Pending covers the gap before the converter reports busy
    wire next_pending = !board_reset && (start || (pending && !CONVERTER_BUSY));
    wire next_status = next_pending || (!board_reset && CONVERTER_BUSY);
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            trig <= 1'b0;
            pending <= 1'b0;
            status_flag <= 1'b0;
            sample <= RESET_SAMPLE;
        end else begin
            trig <= start;
            pending <= next_pending;
            status_flag <= next_status;
            if (board_reset) sample <= RESET_SAMPLE;
            else if (SAMPLE_VALID) sample <= SAMPLE_DATA;  // Two's complement, kept raw
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request flip-flops: set by event, held until cleared
    logic [3:0] req;
    logic [3:0] next_req;
    wire [3:0] req_clear = cmd_pulse[3:0];  // DMA, timer, digital, analog
    wire [3:0] req_enable = {irq_ctrl[3:1], analog_int_en};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_req
            // Set beats a clear in the same cycle
            assign next_req[gi] = !board_reset
                && ((req_enable[gi] && rise[gi]) || (req[gi] && !req_clear[gi]));
        end
    endgenerate
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            req <= 4'h0;
            IRQ <= 1'b0;
        end else begin
            req <= next_req;
            IRQ <= |next_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter control pass-through strobe and read mux
    logic [7:0] ctr_cmd;
    logic ctr_strobe;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = RESET_BYTE;  // Unmapped and unused bits read zero
        unique case (ADDR)
            OFS_CMD_LOW: next_rdata = sample[7:0];
            OFS_SAMPLE_HIGH: next_rdata = sample[15:8];
            OFS_SCAN_RANGE: next_rdata = scan_range;
            OFS_GAIN_STATUS: next_rdata = {status_flag, SINGLE_ENDED, SETTLE_WAIT,
                DAC_BUSY, FIFO_OVERFLOW, gain_scan};
            OFS_IRQ_CTRL: next_rdata = irq_ctrl;
            OFS_FIFO_THRESH: next_rdata = {2'b00, fifo_thresh};
            OFS_DAC_LOW_DEPTH: next_rdata = {2'b00, FIFO_DEPTH};
            OFS_DAC_HIGH_FLAGS: next_rdata = {req, CURRENT_CHANNEL};
            // Direction bit zero is input, so the cleared state releases the pins
            OFS_PORT_A: next_rdata = dir_ctrl[4] ? port_a : PORT_A_IN;
            OFS_PORT_B: next_rdata = dir_ctrl[1] ? port_b : PORT_B_IN;
            OFS_PORT_C: next_rdata = dir_ctrl[3] ? port_c : PORT_C_IN;
            OFS_DIR_CTRL: next_rdata = dir_ctrl;
            OFS_CTR_LOW: next_rdata = ctr_data[7:0];
            OFS_CTR_MID: next_rdata = ctr_data[15:8];
            OFS_CTR_HIGH: next_rdata = ctr_data[23:16];
            OFS_CTR_CTRL_REV: next_rdata = REVISION_CODE;
        endcase
    end
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ctr_cmd <= RESET_BYTE;
            ctr_strobe <= 1'b0;
            rdata <= RESET_BYTE;
        end else begin
            if (board_reset) ctr_cmd <= RESET_BYTE;
            else if (wr_ctr_c) ctr_cmd <= WDATA;
            ctr_strobe <= wr_ctr_c && !board_reset;
            if (RD) rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop
    assign RDATA = rdata;
    assign CONVERSION_TRIGGER = trig;
    assign BOARD_RESET = board_reset;
    assign FIFO_RESET = fifo_reset;
    assign DAC_RESET = dac_reset;
    assign DAC_RESET_VALUE = dac_reset_value;
    assign DAC_LOAD = dac_load;
    assign DAC_CHANNEL = dac_chan;
    assign DAC_CODE = dac_code;
    assign CONVERSION_STATUS_FLAG = status_flag;
    assign REQUEST_FLAGS = req;
    assign PORT_A_OUT = port_a;
    assign PORT_B_OUT = port_b;
    assign PORT_C_OUT = port_c;
    assign DIRECTION = dir_ctrl;
    assign SCAN_RANGE = scan_range;
    assign GAIN_SCAN = gain_scan;
    assign IRQ_CONTROL = irq_ctrl;
    assign FIFO_THRESHOLD = fifo_thresh;
    assign COUNTER_DATA = ctr_data;
    assign COUNTER_COMMAND = ctr_cmd;
    assign COUNTER_COMMAND_STROBE = ctr_strobe;
endmodule : dcr_bank
`default_nettype wire

/* verilog/dcr_pkg.sv */
/*
 Constants for the data acquisition command register bank: byte offsets of
 the sixteen I/O locations, command bit positions, field positions and
 reset values. Assumes a byte-wide host I/O bus with a 4-bit address.
*/
package dcr_pkg;
    localparam logic [3:0] OFS_CMD_LOW = 4'h0;
    localparam logic [3:0] OFS_SAMPLE_HIGH = 4'h1;
    localparam logic [3:0] OFS_SCAN_RANGE = 4'h2;
    localparam logic [3:0] OFS_GAIN_STATUS = 4'h3;
    localparam logic [3:0] OFS_IRQ_CTRL = 4'h4;
    localparam logic [3:0] OFS_FIFO_THRESH = 4'h5;
    localparam logic [3:0] OFS_DAC_LOW_DEPTH = 4'h6;
    localparam logic [3:0] OFS_DAC_HIGH_FLAGS = 4'h7;
    localparam logic [3:0] OFS_PORT_A = 4'h8;
    localparam logic [3:0] OFS_PORT_B = 4'h9;
    localparam logic [3:0] OFS_PORT_C = 4'hA;
    localparam logic [3:0] OFS_DIR_CTRL = 4'hB;
    localparam logic [3:0] OFS_CTR_LOW = 4'hC;
    localparam logic [3:0] OFS_CTR_MID = 4'hD;
    localparam logic [3:0] OFS_CTR_HIGH = 4'hE;
    localparam logic [3:0] OFS_CTR_CTRL_REV = 4'hF;
    // Command bit positions at offset 0
    localparam int CMD_CONVERSION_START = 7;
    localparam int CMD_BOARD_RESET = 6;
    localparam int CMD_ANALOG_OUT_RESET = 5;
    localparam int CMD_FIFO_RESET = 4;
    localparam int CMD_DMA_CLEAR = 3;
    localparam int CMD_TIMER_CLEAR = 2;
    localparam int CMD_DIGITAL_CLEAR = 1;
    localparam int CMD_ANALOG_CLEAR = 0;
    // Interrupt control fields at offset 4
    localparam int CTL_ANALOG_INT_ENABLE = 0;
    localparam int CTL_TRIGGER_SELECT = 4;
    // Writable masks at offsets 3, 5, 7 and 11
    localparam logic [7:0] MASK_GAIN_SCAN = 8'h07;
    localparam logic [7:0] MASK_FIFO_THRESH = 8'h3F;
    localparam logic [7:0] MASK_DAC_HIGH = 8'hCF;
    localparam logic [7:0] MASK_DIR_CTRL = 8'h9B;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [11:0] RESET_DAC = 12'h000;
    localparam logic [11:0] DAC_MID_SCALE = 12'h800;
    localparam logic [11:0] DAC_ZERO_SCALE = 12'h000;
    localparam logic [5:0] RESET_DEPTH = 6'h00;
    localparam logic [15:0] RESET_SAMPLE = 16'h0000;
    localparam int FIFO_DEPTH_MAX = 48;
endpackage : dcr_pkg
